// *** verilog/ufcam_pkg.sv ***
// Shared constants and types for the serial receive checker and address filter.
// Assumes a single core clock domain and a Wishbone classic register bus.
package ufcam_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
  localparam logic [9:0] IDX_SERIAL_CONTROL = 10'h098;
  localparam logic [9:0] IDX_RX_BUFFER = 10'h099;
  localparam logic [9:0] IDX_OWN_ADDRESS = 10'h0A9;
  localparam logic [9:0] IDX_ADDRESS_MASK = 10'h0B9;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0C0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0C1;

  // Serial control bit positions
  localparam int SC_ERR_OR_MODE0 = 7;
  localparam int SC_MODE1 = 6;
  localparam int SC_MP_EN = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;

  // Power control bit that enables framing-error checking
  localparam int PC_CHECK_EN = 6;

  // Interrupt status / mask bit positions
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_FRAME_ERR = 1;

  // Values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_IRQ = 2'h0;

  // Oversampling: last tick index of a bit and tick index of a bit's centre
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ufcam_rx_state_t;

  // One received frame as seen by the checker
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop;
  } ufcam_rx_frame_t;

endpackage

// *** verilog/ufcam_rx_shift.sv ***
// Asynchronous receive shifter: start detect, 8 or 9 data bits, stop sample.
// Assumes a 16x oversampling tick from an outside baud generator.
module ufcam_rx_shift (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick16_i,
  input wire logic rxd_i,
  input wire logic enable_i,
  input wire logic nine_bits_i,
  output ufcam_pkg::ufcam_rx_frame_t frame_o,
  output logic last_bit_o,
  output logic stop_o
);

  ufcam_pkg::ufcam_rx_state_t state;
  logic [3:0] tick_cnt;
  logic [3:0] bit_cnt;
  logic [8:0] shreg;

  // Derived decode of the bit timing
  wire at_half = tick16_i && (tick_cnt == ufcam_pkg::TICK_HALF);
  wire at_centre = tick16_i && (tick_cnt == ufcam_pkg::TICK_LAST);
  wire [3:0] bits_needed = nine_bits_i ? ufcam_pkg::BITS_9 : ufcam_pkg::BITS_8;
  wire [8:0] next_shreg = {rxd_i, shreg[8:1]};
  wire is_last = at_centre && (state == ufcam_pkg::RX_DATA) && (bit_cnt == bits_needed - 4'h1);

  // Bit-state sequencer; a short low glitch is rejected at the half-bit check
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ufcam_pkg::RX_IDLE;
      tick_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      shreg <= 9'h000;
    end
    else if (ce_i)
    begin
      if (tick16_i)
        tick_cnt <= tick_cnt + 4'h1;
      case (state)
        ufcam_pkg::RX_IDLE:
        begin
          tick_cnt <= 4'h0;
          bit_cnt <= 4'h0;
          if (enable_i && tick16_i && !rxd_i)
            state <= ufcam_pkg::RX_START;
        end
        ufcam_pkg::RX_START:
        begin
          if (at_half)
          begin
            tick_cnt <= 4'h0;
            state <= rxd_i ? ufcam_pkg::RX_IDLE : ufcam_pkg::RX_DATA;
          end
        end
        ufcam_pkg::RX_DATA:
        begin
          if (at_centre)
          begin
            shreg <= next_shreg;
            bit_cnt <= bit_cnt + 4'h1;
            if (is_last)
              state <= ufcam_pkg::RX_STOP;
          end
        end
        ufcam_pkg::RX_STOP:
        begin
          if (at_centre)
            state <= ufcam_pkg::RX_IDLE;
        end
        default:
          state <= ufcam_pkg::RX_IDLE;
      endcase
    end
  end

  // Frame fields and completion pulses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_o <= '0;
      last_bit_o <= 1'b0;
      stop_o <= 1'b0;
    end
    else if (ce_i)
    begin
      last_bit_o <= is_last;
      stop_o <= at_centre && (state == ufcam_pkg::RX_STOP);
      if (is_last)
      begin
        frame_o.data <= nine_bits_i ? next_shreg[7:0] : next_shreg[8:1];
        frame_o.ninth <= nine_bits_i ? next_shreg[8] : 1'b0;
      end
      if (at_centre && (state == ufcam_pkg::RX_STOP))
        frame_o.stop <= rxd_i;
    end
  end

endmodule // ufcam_rx_shift

// *** verilog/ufcam_top.sv ***
// Serial receive side: framing-error check, hardware address filter, registers.
// Assumes a Wishbone classic master, a 16x receive tick and a synchronous rxd.
module ufcam_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic rx_tick16_i,
  output logic irq_o
);

  // Software-visible state
  logic mode_select_bit0;
  logic mode_select_bit1;
  logic multiproc_enable;
  logic rx_enable;
  logic tx_ninth_bit;
  logic tx_done_flag;
  logic rx_ninth_bit;
  logic rx_done_flag;
  logic frame_error_flag;
  logic [7:0] power_control_reg;
  logic [7:0] rx_buffer;
  logic [7:0] own_address;
  logic [7:0] address_mask;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] rd_byte;

  ufcam_pkg::ufcam_rx_frame_t frame;
  logic last_bit;
  logic stop_seen;

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_take = bus_req && !wb_ack_o;
  wire bus_wr = bus_take && wb_we_i && wb_sel_i[0];
  wire [7:0] wdat = wb_dat_i[7:0];
  wire sel_pc = (wb_adr_i == ufcam_pkg::IDX_POWER_CONTROL);
  wire sel_sc = (wb_adr_i == ufcam_pkg::IDX_SERIAL_CONTROL);
  wire sel_rb = (wb_adr_i == ufcam_pkg::IDX_RX_BUFFER);
  wire sel_oa = (wb_adr_i == ufcam_pkg::IDX_OWN_ADDRESS);
  wire sel_am = (wb_adr_i == ufcam_pkg::IDX_ADDRESS_MASK);
  wire sel_is = (wb_adr_i == ufcam_pkg::IDX_IRQ_STATUS);
  wire sel_im = (wb_adr_i == ufcam_pkg::IDX_IRQ_MASK);
  wire sc_wr = bus_wr && sel_sc;

  // Mode decode; mode 0 is the shift-register mode and is not received here
  wire frame_error_enable = power_control_reg[ufcam_pkg::PC_CHECK_EN];
  wire mode0 = !mode_select_bit0 && !mode_select_bit1;
  wire mode1 = !mode_select_bit0 && mode_select_bit1;
  wire mode23 = mode_select_bit0;
  wire check_active = frame_error_enable && !mode0;
  wire mp_active = multiproc_enable && !mode0;

  // Address recognition; an all-ones mask makes the given address exact
  wire given_match = ((frame.data ^ own_address) & address_mask) == 8'h00;
  wire [7:0] bcast_addr = own_address | address_mask;
  wire bcast_match = (~frame.data & bcast_addr) == 8'h00;
  wire addr_match = given_match || bcast_match;

  // Completion point: stop bit when checking, or when mode 1 filter needs it
  wire at_stop = check_active || (mp_active && mode1);
  wire done_point = (at_stop ? stop_seen : last_bit) && !mode0;
  wire filter_ok = !mp_active ||
    (mode1 ? (frame.stop && addr_match) : (frame.ninth && addr_match));
  wire rx_event = done_point && filter_ok;
  wire stop_err_event = stop_seen && check_active && !frame.stop;

  // Sticky event bits; a new event wins over a same-cycle clear
  wire [1:0] irq_set = {stop_err_event, rx_event};
  wire [1:0] irq_clr = (bus_wr && sel_is) ? wdat[1:0] : 2'h0;
  wire [1:0] next_irq_status = irq_set | (irq_status & ~irq_clr);
  wire irq_any = |(irq_status & irq_mask);

  // Receiver keeps its own tick, so it never waits on the transmit side
  ufcam_rx_shift u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick16_i(rx_tick16_i),
    .rxd_i(rxd_i),
    .enable_i(rx_enable && !mode0),
    .nine_bits_i(mode23),
    .frame_o(frame),
    .last_bit_o(last_bit),
    .stop_o(stop_seen)
  );

  // Read multiplexer; unmapped indices read as zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (sel_sc)
      rd_byte = {frame_error_enable ? frame_error_flag : mode_select_bit0,
                 mode_select_bit1, multiproc_enable, rx_enable,
                 tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
    else if (sel_pc)
      rd_byte = power_control_reg;
    else if (sel_rb)
      rd_byte = rx_buffer;
    else if (sel_oa)
      rd_byte = own_address;
    else if (sel_am)
      rd_byte = address_mask;
    else if (sel_is)
      rd_byte = {6'h00, irq_status};
    else if (sel_im)
      rd_byte = {6'h00, irq_mask};
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_take;
      if (bus_take)
        wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_control_reg <= ufcam_pkg::RESET_BYTE;
      own_address <= ufcam_pkg::RESET_BYTE;
      address_mask <= ufcam_pkg::RESET_BYTE;
      irq_mask <= ufcam_pkg::RESET_IRQ;
    end
    else if (ce_i)
    begin
      if (bus_wr && sel_pc)
        power_control_reg <= wdat;
      if (bus_wr && sel_oa)
        own_address <= wdat;
      if (bus_wr && sel_am)
        address_mask <= wdat;
      if (bus_wr && sel_im)
        irq_mask <= wdat[1:0];
    end
  end

  // Serial control: bit 7 routes by the checking enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_select_bit0 <= 1'b0;
      mode_select_bit1 <= 1'b0;
      multiproc_enable <= 1'b0;
      rx_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
    end
    else if (ce_i && sc_wr)
    begin
      if (!frame_error_enable)
        mode_select_bit0 <= wdat[ufcam_pkg::SC_ERR_OR_MODE0];
      mode_select_bit1 <= wdat[ufcam_pkg::SC_MODE1];
      multiproc_enable <= wdat[ufcam_pkg::SC_MP_EN];
      rx_enable <= wdat[ufcam_pkg::SC_RX_EN];
      tx_ninth_bit <= wdat[ufcam_pkg::SC_TX_NINTH];
      tx_done_flag <= wdat[ufcam_pkg::SC_TX_DONE];
    end
  end

  // Hardware-set flags; hardware wins over a same-cycle software write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_error_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      rx_ninth_bit <= 1'b0;
    end
    else if (ce_i)
    begin
      if (stop_err_event)
        frame_error_flag <= 1'b1;
      else if (sc_wr && frame_error_enable)
        frame_error_flag <= wdat[ufcam_pkg::SC_ERR_OR_MODE0];
      if (rx_event)
        rx_done_flag <= 1'b1;
      else if (sc_wr)
        rx_done_flag <= wdat[ufcam_pkg::SC_RX_DONE];
      if (rx_event && mode23)
        rx_ninth_bit <= frame.ninth;
      else if (rx_event && at_stop)
        rx_ninth_bit <= frame.stop;
      else if (sc_wr)
        rx_ninth_bit <= wdat[ufcam_pkg::SC_RX_NINTH];
    end
  end

  // Receive data only moves on an accepted frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_buffer <= ufcam_pkg::RESET_BYTE;
    else if (ce_i && rx_event)
      rx_buffer <= frame.data;
  end

  // Interrupt status and level output; output lags the status by one edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= ufcam_pkg::RESET_IRQ;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_status <= next_irq_status;
      irq_o <= irq_any;
    end
  end

  a_err_sets_bad: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && stop_seen && check_active && !frame.stop |=> frame_error_flag)
    else $error("frame error not set on invalid stop bit");

  a_err_stays_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && frame_error_flag &&
    !(sc_wr && frame_error_enable && !wdat[ufcam_pkg::SC_ERR_OR_MODE0])
    |=> frame_error_flag)
    else $error("frame error flag cleared without software");

  a_err_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !check_active && !frame_error_flag && !sc_wr |=> !frame_error_flag)
    else $error("frame error set while checking inactive");

  a_rx_waits_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && last_bit && check_active && !rx_done_flag && !sc_wr |=> !rx_done_flag)
    else $error("receive done raised before stop bit");

  a_mode0_no_rx: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode0 && !rx_done_flag && !sc_wr |=> !rx_done_flag)
    else $error("receive done raised in mode 0");

  a_addr_mismatch: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mp_active && (last_bit || stop_seen) && !addr_match && !rx_done_flag && !sc_wr
    |=> !rx_done_flag)
    else $error("receive done raised on foreign address");

  a_mode1_bad_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mp_active && mode1 && stop_seen && !frame.stop && !rx_done_flag && !sc_wr
    |=> !rx_done_flag)
    else $error("mode 1 address frame accepted with bad stop");

  a_ninth_zero_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mp_active && mode23 && last_bit && !frame.ninth && !rx_done_flag && !sc_wr
    |=> !rx_done_flag)
    else $error("data frame accepted while filtering");

  a_ninth_copied: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rx_event && mode23 |=> rx_ninth_bit == $past(frame.ninth))
    else $error("ninth bit not copied");

  a_match_accepts: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mp_active && mode23 && last_bit && !check_active && frame.ninth && given_match
    |=> rx_done_flag && rx_buffer == $past(frame.data))
    else $error("matching address frame not accepted");

  a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##1 ce_i |-> irq_o == $past(irq_any))
    else $error("interrupt output does not follow masked status");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // Guards written from the rules; all but a_ack_answers still build on the decode wires above
  a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");

  a_err_sw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && sc_wr && frame_error_enable && !stop_err_event &&
    !wdat[ufcam_pkg::SC_ERR_OR_MODE0] |=> !frame_error_flag)
    else $error("frame error flag not cleared by software");

  a_mode_bit_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && sc_wr && frame_error_enable |=> mode_select_bit0 == $past(mode_select_bit0))
    else $error("mode bit written while bit 7 holds the error flag");

  a_stop_sets_done: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && stop_seen && check_active && !mp_active |=> rx_done_flag)
    else $error("receive done not raised at checked stop bit");

  a_no_filter_take: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !multiproc_enable && !mode0 && !check_active && last_bit |=> rx_done_flag)
    else $error("frame dropped with address filter off");

  a_given_accepts: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mp_active && mode23 && last_bit && !check_active && frame.ninth &&
    ((frame.data & address_mask) == (own_address & address_mask)) |=> rx_done_flag)
    else $error("given address frame not accepted");

  a_bcast_accepts: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mp_active && mode23 && last_bit && !check_active && frame.ninth &&
    (&(frame.data | ~(own_address | address_mask))) |=> rx_done_flag)
    else $error("broadcast address frame not accepted");

  a_buffer_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !rx_event |=> rx_buffer == $past(rx_buffer))
    else $error("receive buffer changed without an accepted frame");

  a_mode1_takes: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mp_active && mode1 && stop_seen && frame.stop && addr_match |=> rx_done_flag)
    else $error("mode 1 address frame with valid stop not accepted");

  a_clear_status: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && bus_wr && sel_is && wdat[ufcam_pkg::IRQ_RX_DONE] && !rx_event
    |=> !irq_status[ufcam_pkg::IRQ_RX_DONE])
    else $error("receive status bit not cleared by a one");

endmodule // ufcam_top

// *** test/ufcam_line_model.sv ***
// Far-side model: one sending node on the shared asynchronous serial line.
// Assumes the bench feeds it the same 16x tick that the receiver counts.
module ufcam_line_model (
  input wire logic clk_i,
  input wire logic tick16_i,
  output logic rxd_o,
  output logic in_stop_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Line idles high, as a released line with its pull-up would
  initial rxd_o = 1'b1;
  initial in_stop_o = 1'b0;

  // Holds one level for a full bit time of 16 ticks
  task automatic hold_bit(input logic b);
    rxd_o <= b;
    repeat (16)
    begin
      @(posedge clk_i);
      while (tick16_i !== 1'b1)
        @(posedge clk_i);
    end
  endtask

  // Start, n data bits LSB first, stop, then one idle bit so a bad stop ends
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    hold_bit(1'b0);
    for (int k = 0; k < n; k++)
      hold_bit(d[k]);
    in_stop_o <= 1'b1;
    hold_bit(stop);
    in_stop_o <= 1'b0;
    hold_bit(1'b1);
  endtask
endmodule // ufcam_line_model

// *** test/ufcam_bench.sv ***
// Self-checking bench for the receive checker and address filter.
// Assumes a Wishbone classic slave and a line model feeding rxd.
module ufcam_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
  logic ce = 1'b1;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, rxd, irq, in_stop;
  logic [1:0] tcnt = 2'h0;
  logic [7:0] q;
  int miscompares = 0, compares = 0, cycles = 0;
  // Own, mask, data, ninth, accepted
  logic [25:0] tbl [0:6] = '{{8'hF1, 8'hFA, 8'hF0, 1'b1, 1'b1},
    {8'hF1, 8'hFA, 8'hF3, 1'b1, 1'b0}, {8'hF1, 8'hFA, 8'hFB, 1'b1, 1'b1},
    {8'hF1, 8'hFA, 8'hF0, 1'b0, 1'b0}, {8'h56, 8'hFF, 8'h56, 1'b1, 1'b1},
    {8'h56, 8'hFF, 8'h57, 1'b1, 1'b0}, {8'h56, 8'hFF, 8'hFF, 1'b1, 1'b1}};

  ufcam_top dut_u (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rxd_i(rxd), .rx_tick16_i(tick), .irq_o(irq));
  ufcam_line_model line_u (.clk_i(clk), .tick16_i(tick), .rxd_o(rxd), .in_stop_o(in_stop));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Tick every fourth cycle keeps a frame short; a hang is cut by the ceiling
  always @(posedge clk)
  begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high, then release
  task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= {24'h00_0000, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] exp);
    wb(a, 1'b0, 8'h00);
    check(q & m, exp);
  endtask

  task automatic wsc(input logic [7:0] d);
    wb(ufcam_pkg::IDX_SERIAL_CONTROL, 1'b1, d);
  endtask

  task automatic rsc(input logic [7:0] m, input logic [7:0] exp);
    rd(ufcam_pkg::IDX_SERIAL_CONTROL, m, exp);
  endtask

  task automatic chk_irq(input logic e);
    @(posedge clk);
    check({7'h00, irq}, {7'h00, e});
  endtask

  // Clears status, sends a frame and samples irq a quarter into the stop bit
  task automatic frame(input logic [8:0] d, input int n, input logic stop, input logic e);
    wb(ufcam_pkg::IDX_IRQ_STATUS, 1'b1, 8'h03);
    fork
      line_u.send(d, n, stop);
      begin
        @(posedge in_stop);
        repeat (16) @(posedge clk);
        check({7'h00, irq}, {7'h00, e});
      end
    join
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(ufcam_pkg::IDX_POWER_CONTROL, 8'hFF, 8'h00);
    rsc(8'hFF, 8'h00);
    rd(ufcam_pkg::IDX_OWN_ADDRESS, 8'hFF, 8'h00);
    rd(ufcam_pkg::IDX_ADDRESS_MASK, 8'hFF, 8'h00);
    rd(10'h3FF, 8'hFF, 8'h00);
    wb(ufcam_pkg::IDX_IRQ_MASK, 1'b1, 8'h03);
    // Checking on, mode 1: flag at stop, sticky error
    wb(ufcam_pkg::IDX_POWER_CONTROL, 1'b1, 8'h40);
    wsc(8'h50);
    frame(9'h0A5, 8, 1'b1, 1'b0);
    rsc(8'h81, 8'h01);
    rd(ufcam_pkg::IDX_RX_BUFFER, 8'hFF, 8'hA5);
    frame(9'h03C, 8, 1'b0, 1'b0);
    rsc(8'h80, 8'h80);
    rd(ufcam_pkg::IDX_IRQ_STATUS, 8'h02, 8'h02);
    frame(9'h0C3, 8, 1'b1, 1'b0);
    rsc(8'h80, 8'h80);
    wsc(8'h50);
    rsc(8'h80, 8'h00);
    // Checking off: flag at last data bit, no error on a bad stop
    wb(ufcam_pkg::IDX_POWER_CONTROL, 1'b1, 8'h00);
    frame(9'h0C3, 8, 1'b0, 1'b1);
    rd(ufcam_pkg::IDX_IRQ_STATUS, 8'h02, 8'h00);
    wsc(8'hD0);
    rsc(8'hFF, 8'hD0);
    wb(ufcam_pkg::IDX_POWER_CONTROL, 1'b1, 8'h40);
    rsc(8'h80, 8'h00);
    wb(ufcam_pkg::IDX_POWER_CONTROL, 1'b1, 8'h00);
    wsc(8'hD4);
    frame(9'h02A, 9, 1'b1, 1'b1);
    rsc(8'hFF, 8'hD1);
    // Mode 3 filter; entries five to seven use the all-ones mask
    for (int i = 0; i < 7; i++)
    begin
      wsc(8'hF0);
      wb(ufcam_pkg::IDX_OWN_ADDRESS, 1'b1, tbl[i][25:18]);
      wb(ufcam_pkg::IDX_ADDRESS_MASK, 1'b1, tbl[i][17:10]);
      frame({tbl[i][1], tbl[i][9:2]}, 9, 1'b1, tbl[i][0]);
      rsc(8'h05, tbl[i][0] ? 8'h05 : 8'h00);
    end
    // Mode 2 filters like mode 3: ninth bit one and a match
    wsc(8'hB0);
    frame(9'h156, 9, 1'b1, 1'b1);
    rsc(8'hC5, 8'h85);
    wsc(8'hB0);
    frame(9'h056, 9, 1'b1, 1'b0);
    rsc(8'h05, 8'h00);
    // Mode 1 filter needs a valid stop
    wsc(8'h70);
    frame(9'h056, 8, 1'b0, 1'b0);
    rsc(8'h01, 8'h00);
    frame(9'h056, 8, 1'b1, 1'b0);
    rsc(8'h01, 8'h01);
    wb(ufcam_pkg::IDX_IRQ_MASK, 1'b1, 8'h00);
    chk_irq(1'b0);
    wb(ufcam_pkg::IDX_IRQ_MASK, 1'b1, 8'h01);
    chk_irq(1'b1);
    // Clock enable low stalls the bus answer and holds the interrupt
    ce <= 1'b0;
    fork
      wb(ufcam_pkg::IDX_IRQ_STATUS, 1'b1, 8'h01);
      begin
        repeat (6) @(posedge clk);
        check({7'h00, ack}, 8'h00);
        check({7'h00, irq}, 8'h01);
        ce <= 1'b1;
      end
    join
    chk_irq(1'b0);
    // Mode 0 receives nothing even with the multiprocessor bit set
    wsc(8'h30);
    frame(9'h0E7, 8, 1'b1, 1'b0);
    rsc(8'hFF, 8'h30);
    rd(ufcam_pkg::IDX_RX_BUFFER, 8'hFF, 8'h56);
    close_out();
  end
endmodule // ufcam_bench
